// *** ppm_board.sv ***
// Board model: resolves pin levels from device drive, board drive and pulls
`timescale 1ns/1ps
`default_nettype none
module ppm_board (
  input wire logic clk_sys,
  input wire logic [12:0] dev_o,
  input wire logic [12:0] dev_oe,
  input wire logic [12:0] pu_en,
  input wire logic [12:0] pd_en,
  input wire logic [12:0] ext_en,
  input wire logic [12:0] ext_v,
  output logic [12:0] pin
);
  logic [12:0] flt_q = 13'h0000;
  // Floating pins toggle so a stale level never passes for a driven one
  always_ff @(posedge clk_sys) begin
    flt_q <= ~flt_q;
  end
  always_comb begin
    for (int i = 0; i < 13; i++) begin
      if (dev_oe[i]) pin[i] = dev_o[i];
      else if (ext_en[i]) pin[i] = ext_v[i];
      else if (pu_en[i]) pin[i] = 1'b1;
      else if (pd_en[i]) pin[i] = 1'b0;
      else pin[i] = flt_q[i];
    end
  end
endmodule : ppm_board
`default_nettype wire

// *** ppm_params.svh ***
// Offsets, field positions, reset values and encodings of the port pin mux
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH
`define PPM_A_P2_OUT 4'h0
`define PPM_A_P2_DIR 4'h1
`define PPM_A_P2_PU 4'h2
`define PPM_A_P2_MODE 4'h3
`define PPM_A_P3_OUT 4'h4
`define PPM_A_P3_DIR 4'h5
`define PPM_A_P3_PU 4'h6
`define PPM_A_P3_MODE 4'h7
`define PPM_A_P4_OUT 4'h8
`define PPM_A_P4_DIR 4'h9
`define PPM_A_P4_PU 4'ha
`define PPM_A_EDGE 4'hb
`define PPM_A_IRQ_STAT 4'hc
`define PPM_A_IRQ_MASK 4'hd
`define PPM_A_PIN_P23 4'he
`define PPM_A_PIN_P4 4'hf
`define PPM_IX_P2 0
`define PPM_IX_P32 4
`define PPM_IX_P34 5
`define PPM_IX_P4 6
`define PPM_NSYNC 14
`define PPM_RST_P2 4'h0
`define PPM_RST_P3 1'b0
`define PPM_RST_P4 8'h00
`define PPM_RST_EDGE 4'h0
`define PPM_EDGE_NONE 2'h0
`define PPM_EDGE_RISE 2'h1
`define PPM_EDGE_FALL 2'h2
`define PPM_EDGE_BOTH 2'h3
`define PPM_ST_POR 2'h1
`define PPM_ST_RUN 2'h2
`endif

// *** ppm_pkg.sv ***
// Types of the port pin mux
`include "ppm_params.svh"
package ppm_pkg;
  typedef enum logic [1:0] {
    ST_POR = `PPM_ST_POR,
    ST_RUN = `PPM_ST_RUN
  } ppm_state_t;

  typedef struct packed {
    ppm_state_t st;
    logic [3:0] p2_out;
    logic [3:0] p2_dir;
    logic [3:0] p2_pu;
    logic [3:0] p2_mode;
    logic p3_out;
    logic p3_dir;
    logic p3_pu;
    logic p3_mode;
    logic [7:0] p4_out;
    logic [7:0] p4_dir;
    logic [7:0] p4_pu;
    logic [3:0] edge_cfg;
    logic [1:0] stat;
    logic [1:0] mask;
    logic opt_osc;
    logic opt_rst;
    logic [`PPM_NSYNC-1:0] s1;
    logic [`PPM_NSYNC-1:0] s2;
    logic [`PPM_NSYNC-1:0] s3;
    logic [`PPM_NSYNC-1:0] filt;
    logic [7:0] rdata;
    logic irq;
    logic [3:0] p2_o;
    logic [3:0] p2_oe;
    logic [3:0] p2_puo;
    logic [1:0] p2_pd;
    logic p3_o;
    logic p3_oe;
    logic p3_puo;
    logic [7:0] p4_o;
    logic [7:0] p4_oe;
    logic [7:0] p4_puo;
    logic [3:0] ana_sel;
    logic cnt_clk;
    logic cap_a;
    logic cap_b;
    logic [1:0] irq_pulse;
    logic rst_req_n;
  } ppm_regs_t;
endpackage : ppm_pkg

// *** ppm_port_pin_function_mux.sv ***
// Port 2/3/4 pin logic with alternate function routing and pin interrupts
`timescale 1ns/1ps
`default_nettype none
`include "ppm_params.svh"

module ppm_port_pin_function_mux (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire logic opt_osc_sel,
  input wire logic opt_reset_sel,
  input wire logic [3:0] port2_pin_i,
  output logic [3:0] port2_pin_o,
  output logic [3:0] port2_pin_oe,
  output logic [3:0] port2_pullup_en,
  output logic [1:0] port2_pulldown_en,
  input wire logic port3_io_pin_i,
  output logic port3_io_pin_o,
  output logic port3_io_pin_oe,
  output logic port3_pullup_en,
  input wire logic port3_input_pin_i,
  input wire logic [7:0] port4_pins_i,
  output logic [7:0] port4_pins_o,
  output logic [7:0] port4_pins_oe,
  output logic [7:0] port4_pullup_en,
  input wire logic timer16_out,
  input wire logic timer8_out,
  output logic [3:0] analog_in_sel,
  output logic timer_count_capture_in,
  output logic capture_reg_a_trig,
  output logic capture_reg_b_trig,
  output logic ext_irq_in0,
  output logic ext_irq_in1,
  output logic sys_reset_req_n
);

  ppm_pkg::ppm_regs_t q;
  ppm_pkg::ppm_regs_t d;
  logic [`PPM_NSYNC-1:0] pins_in;

  function automatic logic edge_hit(input logic [1:0] cfg, input logic old_v,
                                    input logic new_v);
    logic rise;
    logic fall;
    rise = !old_v && new_v;
    fall = old_v && !new_v;
    unique case (cfg)
      `PPM_EDGE_NONE: edge_hit = 1'b0;
      `PPM_EDGE_RISE: edge_hit = rise;
      `PPM_EDGE_FALL: edge_hit = fall;
      `PPM_EDGE_BOTH: edge_hit = rise || fall;
    endcase
  endfunction : edge_hit

  assign pins_in = {port4_pins_i, port3_input_pin_i, port3_io_pin_i, port2_pin_i};

  always_comb begin
    logic wr_one;
    logic [1:0] ev;
    logic [3:0] p2_osc;
    wr_one = 1'b0;
    ev = 2'b00;
    p2_osc = 4'h0;
    d = q;
    // Three-stage pin sync; a change is taken once stages two and three agree
    d.s1 = pins_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < `PPM_NSYNC; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.filt[i] = q.s3[i];
      end
    end
    // Straps are caught once, in the first cycle after reset release
    unique case (q.st)
      ppm_pkg::ST_POR: begin
        d.opt_osc = opt_osc_sel;
        d.opt_rst = opt_reset_sel;
        d.st = ppm_pkg::ST_RUN;
      end
      ppm_pkg::ST_RUN: begin
      end
    endcase
    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `PPM_A_P2_OUT: d.p2_out = reg_wdata[3:0];
        `PPM_A_P2_DIR: d.p2_dir = reg_wdata[3:0];
        `PPM_A_P2_PU: d.p2_pu = reg_wdata[3:0];
        `PPM_A_P2_MODE: d.p2_mode = reg_wdata[3:0];
        `PPM_A_P3_OUT: d.p3_out = reg_wdata[0];
        `PPM_A_P3_DIR: d.p3_dir = reg_wdata[0];
        `PPM_A_P3_PU: d.p3_pu = reg_wdata[0];
        `PPM_A_P3_MODE: d.p3_mode = reg_wdata[0];
        `PPM_A_P4_OUT: d.p4_out = reg_wdata;
        `PPM_A_P4_DIR: d.p4_dir = reg_wdata;
        `PPM_A_P4_PU: d.p4_pu = reg_wdata;
        `PPM_A_EDGE: d.edge_cfg = reg_wdata[3:0];
        `PPM_A_IRQ_STAT: wr_one = 1'b1;
        `PPM_A_IRQ_MASK: d.mask = reg_wdata[1:0];
        default: begin
        end
      endcase
    end
    // Read data stands only in the cycle after the strobe
    d.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `PPM_A_P2_OUT: d.rdata = {4'h0, q.p2_out};
        `PPM_A_P2_DIR: d.rdata = {4'h0, q.p2_dir};
        `PPM_A_P2_PU: d.rdata = {4'h0, q.p2_pu};
        `PPM_A_P2_MODE: d.rdata = {4'h0, q.p2_mode};
        `PPM_A_P3_OUT: d.rdata = {7'h00, q.p3_out};
        `PPM_A_P3_DIR: d.rdata = {7'h00, q.p3_dir};
        `PPM_A_P3_PU: d.rdata = {7'h00, q.p3_pu};
        `PPM_A_P3_MODE: d.rdata = {7'h00, q.p3_mode};
        `PPM_A_P4_OUT: d.rdata = q.p4_out;
        `PPM_A_P4_DIR: d.rdata = q.p4_dir;
        `PPM_A_P4_PU: d.rdata = q.p4_pu;
        `PPM_A_EDGE: d.rdata = {4'h0, q.edge_cfg};
        `PPM_A_IRQ_STAT: d.rdata = {6'h00, q.stat};
        `PPM_A_IRQ_MASK: d.rdata = {6'h00, q.mask};
        `PPM_A_PIN_P23: d.rdata = {2'h0, q.filt[5:0]};
        `PPM_A_PIN_P4: d.rdata = q.filt[13:6];
      endcase
    end
    // Pin interrupts; a new edge wins over a write-one clear in the same cycle
    ev[0] = q.p2_mode[1] && edge_hit(q.edge_cfg[1:0], q.filt[1], d.filt[1]);
    ev[1] = q.p3_mode && edge_hit(q.edge_cfg[3:2], q.filt[4], d.filt[4]);
    d.irq_pulse = ev;
    d.stat = (q.stat & ~(wr_one ? reg_wdata[1:0] : 2'b00)) | ev;
    d.irq = |(d.stat & d.mask);
    // Port 2 drivers; oscillator pins are released to the crystal
    p2_osc = {q.opt_osc, q.opt_osc, 2'b00};
    d.p2_o = q.p2_out;
    if (q.p2_mode[1]) begin
      d.p2_o[1] = timer16_out;
    end
    if (q.p2_mode[0]) begin
      d.p2_o[0] = timer8_out;
    end
    d.p2_oe = q.p2_dir & ~p2_osc;
    d.p2_puo = q.p2_pu & ~q.p2_dir & ~p2_osc;
    d.p2_pd = (q.st == ppm_pkg::ST_POR) ? 2'b11 : 2'b00;
    d.ana_sel = q.p2_mode & ~q.p2_dir & ~p2_osc;
    // Timer inputs follow the filtered pin levels in control mode
    d.cnt_clk = q.p2_mode[0] && d.filt[0];
    d.cap_b = q.p2_mode[0] && (q.filt[0] != d.filt[0]);
    d.cap_a = d.cap_b || (q.p2_mode[1] && (q.filt[1] != d.filt[1]));
    // Port 3 and port 4
    d.p3_o = q.p3_out;
    d.p3_oe = q.p3_dir;
    d.p3_puo = q.p3_pu && !q.p3_dir;
    d.p4_o = q.p4_out;
    d.p4_oe = q.p4_dir;
    d.p4_puo = q.p4_pu & ~q.p4_dir;
    // Reset function holds until the strap has been read
    if (q.st == ppm_pkg::ST_POR || q.opt_rst) begin
      d.rst_req_n = d.filt[`PPM_IX_P34];
    end else begin
      d.rst_req_n = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.st <= ppm_pkg::ST_POR;
      q.p2_out <= `PPM_RST_P2;
      q.p2_dir <= `PPM_RST_P2;
      q.p2_pu <= `PPM_RST_P2;
      q.p2_mode <= `PPM_RST_P2;
      q.p3_dir <= `PPM_RST_P3;
      q.p3_pu <= `PPM_RST_P3;
      q.p4_dir <= `PPM_RST_P4;
      q.p4_pu <= `PPM_RST_P4;
      q.edge_cfg <= `PPM_RST_EDGE;
      q.opt_rst <= 1'b1;
      q.s1 <= {`PPM_NSYNC{1'b1}};
      q.s2 <= {`PPM_NSYNC{1'b1}};
      q.s3 <= {`PPM_NSYNC{1'b1}};
      q.filt <= {`PPM_NSYNC{1'b1}};
      q.p2_pd <= 2'b11;
      q.rst_req_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign irq = q.irq;
  assign port2_pin_o = q.p2_o;
  assign port2_pin_oe = q.p2_oe;
  assign port2_pullup_en = q.p2_puo;
  assign port2_pulldown_en = q.p2_pd;
  assign port3_io_pin_o = q.p3_o;
  assign port3_io_pin_oe = q.p3_oe;
  assign port3_pullup_en = q.p3_puo;
  assign port4_pins_o = q.p4_o;
  assign port4_pins_oe = q.p4_oe;
  assign port4_pullup_en = q.p4_puo;
  assign analog_in_sel = q.ana_sel;
  assign timer_count_capture_in = q.cnt_clk;
  assign capture_reg_a_trig = q.cap_a;
  assign capture_reg_b_trig = q.cap_b;
  assign ext_irq_in0 = q.irq_pulse[0];
  assign ext_irq_in1 = q.irq_pulse[1];
  assign sys_reset_req_n = q.rst_req_n;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_p32_rise;
    q.p3_mode && q.edge_cfg[3:2] == `PPM_EDGE_RISE && !q.filt[4] ##1 q.filt[4];
  endsequence

  sequence s_stat_clear;
    reg_wr && reg_addr == `PPM_A_IRQ_STAT && reg_wdata[0] && q.irq_pulse == 2'b00;
  endsequence

  a_irq_level_mask: assert property (irq == |(q.stat & q.mask))
    else $error("irq output differs from masked status");
  a_p32_edge_flag: assert property (s_p32_rise |-> q.stat[1] && ext_irq_in1)
    else $error("rising edge on port3 io pin did not set status");
  a_stat_w1c: assert property (s_stat_clear ##1 !ev_next0() |-> !q.stat[0])
    else $error("status bit 0 not cleared by write one");
  a_t16_drive: assert property (q.p2_mode[1] |=> port2_pin_o[1] == $past(timer16_out))
    else $error("port2 pin1 not driven by 16-bit timer");
  a_t8_drive: assert property (q.p2_mode[0] |=> port2_pin_o[0] == $past(timer8_out))
    else $error("port2 pin0 not driven by 8-bit timer");
  a_pulldown_run: assert property (q.st == ppm_pkg::ST_RUN |=> port2_pulldown_en == 2'b00)
    else $error("pull-down left on after reset");
  a_por_inputs: assert property (q.st == ppm_pkg::ST_POR |-> port2_pin_oe == 4'h0
      && port4_pins_oe == 8'h00 && port4_pullup_en == 8'h00)
    else $error("pins not inputs without pull-up after reset");
  a_filter_hold: assert property (q.s2 != q.s3 |=> (($past(q.s2) ^ $past(q.s3))
      & (q.filt ^ $past(q.filt))) == '0)
    else $error("filtered pin changed while sync stages disagree");
  a_osc_release: assert property (q.opt_osc |=> port2_pin_oe[3:2] == 2'b00
      && analog_in_sel[3:2] == 2'b00)
    else $error("oscillator pins driven or routed to converter");
  a_analog_route: assert property (q.p2_mode[0] && !q.p2_dir[0]
      |=> analog_in_sel[0])
    else $error("control-mode input pin not routed to converter");
  a_reset_pin: assert property (q.opt_rst && q.s2[5] == q.s3[5] && !q.s3[5]
      |=> !sys_reset_req_n)
    else $error("reset pin low did not request reset");

  // Direction and pull-up outputs follow their registers one cycle later
  a_p2_dir_oe: assert property (!q.opt_osc |=> port2_pin_oe == $past(q.p2_dir))
    else $error("port2 enables differ from direction bits");

  a_p2_pu_in: assert property (q.p2_pu[0] && !q.p2_dir[0] |=> port2_pullup_en[0])
    else $error("port2 input pin0 pull-up not connected");

  a_p2_pu_out: assert property (q.p2_dir[1] |=> !port2_pullup_en[1])
    else $error("port2 output pin1 still has pull-up");

  a_p3_dir_oe: assert property (1'b1 |=> port3_io_pin_oe == $past(q.p3_dir))
    else $error("port3 io enable differs from direction bit");

  a_p3_pu_in: assert property (q.p3_pu && !q.p3_dir |=> port3_pullup_en)
    else $error("port3 io pull-up not connected");

  a_p3_latch: assert property (1'b1 |=> port3_io_pin_o == $past(q.p3_out))
    else $error("port3 io level differs from latch");

  a_p4_dir_oe: assert property (1'b1 |=> port4_pins_oe == $past(q.p4_dir))
    else $error("port4 enables differ from direction bits");

  a_p4_pu_excl: assert property ((port4_pullup_en & port4_pins_oe) == 8'h00)
    else $error("port4 pull-up on a driven pin");

  a_p4_latch: assert property (1'b1 |=> port4_pins_o == $past(q.p4_out))
    else $error("port4 levels differ from latch");

  // Timer inputs only see pins that are in control mode
  a_count_clk: assert property (q.p2_mode[0] && q.s2[0] == q.s3[0]
      |=> timer_count_capture_in == $past(q.s3[0]))
    else $error("count input does not follow pin0");

  a_cap_b_gate: assert property (!q.p2_mode[0] |=> !capture_reg_b_trig)
    else $error("capture b fired with pin0 in port mode");

  a_cap_a_both: assert property (capture_reg_b_trig |-> capture_reg_a_trig)
    else $error("pin0 edge did not trigger capture a");

  // Interrupt pulses need control mode and an enabled edge
  a_irq0_gate: assert property (!q.p2_mode[1] |=> !ext_irq_in0)
    else $error("irq0 pulse with pin1 in port mode");

  a_irq1_gate: assert property (!q.p3_mode |=> !ext_irq_in1)
    else $error("irq1 pulse with port3 io pin in port mode");

  a_edge_none: assert property (q.edge_cfg[1:0] == `PPM_EDGE_NONE |=> !ext_irq_in0)
    else $error("irq0 pulse with no edge selected");

  // Pin drive, converter routing, oscillator and reset options
  a_p2_latch: assert property (!q.p2_mode[1] |=> port2_pin_o[1] == $past(q.p2_out[1]))
    else $error("port-mode pin1 not driven from latch");

  a_analog_dir: assert property (q.p2_dir[1] |=> !analog_in_sel[1])
    else $error("output pin routed to converter");

  a_analog_pin2: assert property (q.p2_mode[2] && !q.p2_dir[2] && !q.opt_osc
      |=> analog_in_sel[2])
    else $error("control-mode pin2 not routed to converter");

  a_osc_nopull: assert property (q.opt_osc |=> port2_pullup_en[3:2] == 2'b00)
    else $error("oscillator pins have pull-up");

  a_pd_por: assert property (q.st == ppm_pkg::ST_POR |-> port2_pulldown_en == 2'b11)
    else $error("pull-down off before straps are read");

  a_rst_gp: assert property (!q.opt_rst && q.st == ppm_pkg::ST_RUN |=> sys_reset_req_n)
    else $error("general input pin requested reset");

  function automatic logic ev_next0();
    ev_next0 = q.irq_pulse[0];
  endfunction : ev_next0

endmodule : ppm_port_pin_function_mux
`default_nettype wire

// *** ppm_tb.sv ***
// Self-checking bench for the port pin mux
`timescale 1ns/1ps
`default_nettype none
`include "ppm_params.svh"
module tb;
  logic clk_sys, resetn, reg_wr, reg_rd, osc, rsel, p34, t16, t8;
  logic irq, p3_o, p3_oe, p3_pu, tcc, ca, cb, ei0, ei1, rst_n;
  logic [1:0] pd;
  logic [3:0] reg_addr, p2_o, p2_oe, p2_pu, ana;
  logic [7:0] reg_wdata, reg_rdata, rv, p4_o, p4_oe, p4_pu;
  logic [12:0] pin, ext_en, ext_v;
  int fails, compares, n0, n1, na, nb;
  ppm_port_pin_function_mux uut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .opt_osc_sel(osc), .opt_reset_sel(rsel), .port2_pin_i(pin[3:0]),
    .port2_pin_o(p2_o), .port2_pin_oe(p2_oe), .port2_pullup_en(p2_pu),
    .port2_pulldown_en(pd), .port3_io_pin_i(pin[4]), .port3_io_pin_o(p3_o),
    .port3_io_pin_oe(p3_oe), .port3_pullup_en(p3_pu), .port3_input_pin_i(p34),
    .port4_pins_i(pin[12:5]), .port4_pins_o(p4_o), .port4_pins_oe(p4_oe),
    .port4_pullup_en(p4_pu), .timer16_out(t16), .timer8_out(t8), .analog_in_sel(ana),
    .timer_count_capture_in(tcc), .capture_reg_a_trig(ca), .capture_reg_b_trig(cb),
    .ext_irq_in0(ei0), .ext_irq_in1(ei1), .sys_reset_req_n(rst_n));
  ppm_board board (.clk_sys(clk_sys), .dev_o({p4_o, p3_o, p2_o}),
    .dev_oe({p4_oe, p3_oe, p2_oe}), .pu_en({p4_pu, p3_pu, p2_pu}),
    .pd_en({9'h000, pd, 2'h0}), .ext_en(ext_en), .ext_v(ext_v), .pin(pin));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Pulses last one cycle, so count them mid-cycle where they are settled
  always @(negedge clk_sys) begin
    n0 += (ei0 === 1'b1);
    n1 += (ei1 === 1'b1);
    na += (ca === 1'b1);
    nb += (cb === 1'b1);
  end
  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] e, input string m);
    compares++;
    if (got !== e) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic chkrd(input logic [3:0] a, input logic [7:0] e, input string m);
    rd(a, rv);
    chk(rv, e, m);
  endtask : chkrd
  task automatic rst(input logic o, input logic r);
    @(posedge clk_sys);
    resetn <= 1'b0;
    osc <= o;
    rsel <= r;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({6'h00, pd}, 8'h03, "pulldown");
    chk({p2_oe, p2_pu}, 8'h00, "p2 cfg");
    chk(p4_oe | p4_pu, 8'h00, "p4 cfg");
    chk({6'h00, p3_oe, p3_pu}, 8'h00, "p3 cfg");
    @(posedge clk_sys);
    resetn <= 1'b1;
    tick(3);
    chk({6'h00, pd}, 8'h00, "pulldown off");
    $display("done reset");
  endtask : rst
  task automatic t_regs();
    logic [3:0] a[6] = '{`PPM_A_P2_DIR, `PPM_A_P2_PU, `PPM_A_P3_DIR, `PPM_A_P3_PU,
                         `PPM_A_P4_DIR, `PPM_A_P4_PU};
    foreach (a[i]) chkrd(a[i], 8'h00, "reset reg");
    $display("done regs");
  endtask : t_regs
  task automatic t_p2();
    wr(`PPM_A_P2_OUT, 8'h05);
    wr(`PPM_A_P2_DIR, 8'h05);
    ext_en <= 13'h001a;
    ext_v <= 13'h0012;
    wr(`PPM_A_P2_PU, 8'h0f);
    tick(8);
    chk({p2_oe, p2_o & p2_oe}, 8'h55, "p2 drive");
    chk({4'h0, p2_pu}, 8'h0a, "p2 pullup");
    chkrd(`PPM_A_PIN_P23, 8'h37, "p2 pins");
    $display("done port2");
  endtask : t_p2
  task automatic t_tmr();
    t16 <= 1'b1;
    wr(`PPM_A_P2_DIR, 8'h07);
    wr(`PPM_A_P2_MODE, 8'h03);
    tick(3);
    chk({4'h0, p2_o & p2_oe}, 8'h06, "tmr out");
    t16 <= 1'b0;
    tick(3);
    chk({4'h0, p2_o & p2_oe}, 8'h04, "tmr follow");
    $display("done timer out");
  endtask : t_tmr
  task automatic t_tin();
    int a0, b0, z0;
    wr(`PPM_A_P2_DIR, 8'h00);
    wr(`PPM_A_P2_MODE, 8'h0f);
    ext_en <= 13'h001b;
    ext_v <= 13'h0010;
    tick(8);
    chk({4'h0, ana}, 8'h0f, "analog");
    a0 = na;
    b0 = nb;
    z0 = n0;
    ext_v <= 13'h0011;
    tick(8);
    chk({7'h00, tcc}, 8'h01, "count in");
    chk(8'(nb - b0), 8'h01, "cap b");
    ext_v <= 13'h0013;
    tick(8);
    chk(8'(na - a0), 8'h02, "cap a");
    chk(8'(nb - b0), 8'h01, "cap b only pin0");
    chk(8'(n0 - z0), 8'h00, "edge none");
    $display("done timer in");
  endtask : t_tin
  task automatic t_irq();
    int c0, c1;
    wr(`PPM_A_P3_MODE, 8'h01);
    wr(`PPM_A_IRQ_MASK, 8'h03);
    for (int e = 1; e < 4; e++) begin
      ext_v <= 13'h0000;
      wr(`PPM_A_EDGE, 8'(e * 5));
      tick(8);
      wr(`PPM_A_IRQ_STAT, 8'h03);
      c0 = n0;
      c1 = n1;
      ext_v <= 13'h0012;
      tick(8);
      ext_v <= 13'h0000;
      tick(8);
      chk(8'(n0 - c0), (e == 3) ? 8'h02 : 8'h01, "irq0 edges");
      chk(8'(n1 - c1), (e == 3) ? 8'h02 : 8'h01, "irq1 edges");
      chk({7'h00, irq}, 8'h01, "irq on");
    end
    wr(`PPM_A_IRQ_STAT, 8'h03);
    tick(2);
    chk({7'h00, irq}, 8'h00, "irq clear");
    wr(`PPM_A_IRQ_MASK, 8'h00);
    ext_v <= 13'h0012;
    tick(8);
    chkrd(`PPM_A_IRQ_STAT, 8'h03, "sticky");
    chk({7'h00, irq}, 8'h00, "masked");
    $display("done irq");
  endtask : t_irq
  task automatic t_p3p4();
    wr(`PPM_A_P3_MODE, 8'h00);
    ext_en <= 13'h1e00;
    ext_v <= 13'h1200;
    wr(`PPM_A_P3_PU, 8'h01);
    tick(2);
    chk({6'h00, p3_oe, p3_pu}, 8'h01, "p3 in pu");
    wr(`PPM_A_P3_OUT, 8'h01);
    wr(`PPM_A_P3_DIR, 8'h01);
    wr(`PPM_A_P4_OUT, 8'ha5);
    wr(`PPM_A_P4_DIR, 8'h0f);
    wr(`PPM_A_P4_PU, 8'hff);
    p34 <= 1'b0;
    tick(8);
    chk({5'h00, p3_oe, p3_o, p3_pu}, 8'h06, "p3 out");
    chk(p4_oe, 8'h0f, "p4 dir");
    chk(p4_pu, 8'hf0, "p4 pu");
    chkrd(`PPM_A_PIN_P4, 8'h95, "p4 pins");
    chk({7'h00, rst_n}, 8'h00, "reset pin");
    p34 <= 1'b1;
    $display("done port3 port4");
  endtask : t_p3p4
  task automatic t_opt();
    wr(`PPM_A_P2_PU, 8'h0f);
    wr(`PPM_A_P2_MODE, 8'h0f);
    p34 <= 1'b0;
    tick(8);
    chk({p2_pu, ana}, 8'h33, "osc pins");
    chk({7'h00, rst_n}, 8'h01, "gp input");
    rd(`PPM_A_PIN_P23, rv);
    chk(rv & 8'h20, 8'h00, "p34 read");
    $display("done options");
  endtask : t_opt
  initial begin
    {resetn, reg_wr, reg_rd, osc, t16, t8} = '0;
    {rsel, p34} = 2'b11;
    {reg_addr, reg_wdata, ext_en, ext_v} = '0;
    rst(1'b0, 1'b1);
    t_regs();
    t_p2();
    t_tmr();
    t_tin();
    t_irq();
    t_p3p4();
    rst(1'b1, 1'b0);
    t_opt();
    report_and_stop();
  end
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
